// ---- core/vlan_stats_map.svh ----
/*
 Offsets, field positions, reset values and timing figures of the
 VLAN frame statistics block. Definitions only; included by the package.
*/
`ifndef VLAN_STATS_MAP_SVH
`define VLAN_STATS_MAP_SVH

// Register byte offsets and counter page numbers
`define OFS_CTRL      8'h00
`define OFS_SEL       8'h04
`define OFS_STATUS    8'h08
`define OFS_UPTIME    8'h0C
`define DIR_RX_PAGE   2'h1
`define DIR_TX_PAGE   2'h2

// Command bits of the control register
`define CMD_START     0
`define CMD_STOP      1
`define CMD_REFRESH   2
`define CMD_CLEAR     3

// Field positions
`define SEL_VID_LSB   0
`define SEL_PORT_LSB  16
`define STAT_RUN_BIT  0
`define STAT_VID_LSB  4
`define STAT_PORT_LSB 16

// Widths and reset values
`define VID_W         12
`define PORT_W        4
`define LEN_W         14
`define VID_DEF       12'h001
`define PORT_DEF      4'h0

// Counter slots of one direction
`define NCNT          11
`define IX_RATE       0
`define IX_BYTES      1
`define IX_MCAST      2
`define IX_BCAST      3
`define IX_B64        4
`define IX_GIANT      10

// Histogram bin bounds (upper bound of each bin, octets)
`define LEN_64        14'h0040
`define LEN_127       14'h007F
`define LEN_255       14'h00FF
`define LEN_511       14'h01FF
`define LEN_1023      14'h03FF
`define LEN_1518      14'h05EE
`define MAX_FRAME_DEF 14'h2400

// Rate window and clock
`define KB_BYTES      18'h0_03E8
`define RATE_WIN_MS   1000
`define CLK_KHZ       125000

`endif

// ---- core/vlan_stats_pkg.sv ----
/*
 Types and the saturating adder shared by the statistics block.
 Assumes the map header is on the include path.
*/
`include "vlan_stats_map.svh"

package vlan_stats_pkg;
	typedef logic [`NCNT-1:0][31:0] cnt_set_t;
	typedef logic [1:0][`NCNT-1:0][31:0] snap_t;

	function automatic logic [31:0] sat_add(input logic [31:0] a, input logic [31:0] b);
		logic [32:0] s;
		s = {1'b0, a} + {1'b0, b};
		return s[32] ? '1 : s[31:0];
	endfunction
endpackage

// ---- core/stats_dir.sv ----
/*
 One direction's counter set: bytes, rate, multicast, broadcast and the
 length histogram. Assumes frame inputs come from logic on the same clock.
*/
`timescale 1ns/1ns
`include "vlan_stats_map.svh"

module stats_dir #(
	parameter logic [`LEN_W-1:0] MAX_FRAME = `MAX_FRAME_DEF
) (
	input  wire logic                   clk,     // System clock
	input  wire logic                   nrst,    // Async reset, low
	input  wire logic                   eof,     // Frame end pulse
	input  wire logic                   match,   // Frame is on monitored VLAN and port
	input  wire logic [`LEN_W-1:0]      len,     // Frame length, octets
	input  wire logic                   mcast,   // Multicast destination
	input  wire logic                   bcast,   // Broadcast destination
	input  wire logic                   err,     // Errored frame
	input  wire logic                   clear,   // Zero all counters
	input  wire logic                   tick,    // One rate window elapsed
	output vlan_stats_pkg::cnt_set_t    cnt_o    // Live counters
);
	import vlan_stats_pkg::*;

	typedef struct packed {
		cnt_set_t    cnt;
		logic [31:0] kb;
		logic [17:0] rem;
	} dir_st_t;

	dir_st_t s_r;
	dir_st_t s_nxt;

	always_comb begin
		s_nxt = s_r;
		// One kilobyte drained per cycle; a frame always lasts longer than that
		if (s_nxt.rem >= `KB_BYTES) begin
			s_nxt.rem = s_nxt.rem - `KB_BYTES;
			s_nxt.kb  = sat_add(s_nxt.kb, 32'h0000_0001);
		end
		if (tick) begin
			s_nxt.cnt[`IX_RATE] = s_nxt.kb; // R7
			s_nxt.kb            = '0;
		end
		if (eof && match) begin
			s_nxt.cnt[`IX_BYTES] = sat_add(s_nxt.cnt[`IX_BYTES], 32'(len)); // R6 R18
			s_nxt.rem            = s_nxt.rem + 18'(len);
			if (mcast && !err)
				s_nxt.cnt[`IX_MCAST] = sat_add(s_nxt.cnt[`IX_MCAST], 32'h0000_0001); // R8
			if (bcast && !err)
				s_nxt.cnt[`IX_BCAST] = sat_add(s_nxt.cnt[`IX_BCAST], 32'h0000_0001); // R9
			if (len == `LEN_64)
				s_nxt.cnt[4] = sat_add(s_nxt.cnt[4], 32'h0000_0001); // R10
			else if (len > `LEN_64 && len <= `LEN_127)
				s_nxt.cnt[5] = sat_add(s_nxt.cnt[5], 32'h0000_0001); // R11
			else if (len > `LEN_127 && len <= `LEN_255)
				s_nxt.cnt[6] = sat_add(s_nxt.cnt[6], 32'h0000_0001); // R12
			else if (len > `LEN_255 && len <= `LEN_511)
				s_nxt.cnt[7] = sat_add(s_nxt.cnt[7], 32'h0000_0001); // R13
			else if (len > `LEN_511 && len <= `LEN_1023)
				s_nxt.cnt[8] = sat_add(s_nxt.cnt[8], 32'h0000_0001); // R14
			else if (len > `LEN_1023 && len <= `LEN_1518)
				s_nxt.cnt[9] = sat_add(s_nxt.cnt[9], 32'h0000_0001); // R15
			else if (len > `LEN_1518 && len <= MAX_FRAME)
				s_nxt.cnt[`IX_GIANT] = sat_add(s_nxt.cnt[`IX_GIANT], 32'h0000_0001); // R16
		end
		// Clear beats a frame ending in the same cycle
		if (clear)
			s_nxt = '0; // R5
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

	assign cnt_o = s_r.cnt;

	rate_load_a: assert property (@(posedge clk) disable iff (!nrst) // R7
		tick && !clear |=> s_r.cnt[`IX_RATE] == $past(s_r.kb) + {31'h0, $past(s_r.rem) >= `KB_BYTES}
			|| $past(s_r.kb) == '1)
		else $error("rate not loaded from window count");
endmodule

// ---- core/vlan_stats.sv ----
/*
 VLAN frame statistics collector with a classic Wishbone register slave.
 Assumes RX and TX frame-end strobes come from logic on CLK_SYS.
*/
// The placing of the registers and the Wishbone interface to the registers were left to the implementer.
// How it works
// R1: Start arms counting of matching VLAN and port frames, RX and TX apart.
// R2: Stop, refresh and clear only act while collection runs.
// R3: Stop halts collection and returns VLAN and port to defaults.
// R4: Refresh copies live counters into the readable snapshot.
// R5: Clear zeroes every counter of the monitored port.
// R6: Bytes of matching frames are summed per direction.
// R7: Kilobytes per second are kept per direction.
// R8: Good multicast frames are counted per direction, errored ones not.
// R9: Good broadcast frames are counted per direction, errored ones not.
// R10: Frames of exactly 64 octets bump the first bin, errors included.
// R11: Frames of 65 to 127 octets bump their bin, errors included.
// R12: Frames of 128 to 255 octets bump their bin, errors included.
// R13: Frames of 256 to 511 octets bump their bin, errors included.
// R14: Frames of 512 to 1023 octets bump their bin, errors included.
// R15: Frames of 1024 to 1518 octets bump their bin, errors included.
// R16: Frames of 1519 up to the maximum bump the giant bin.
// R17: Seconds since reset are counted and readable.
// R18: Counters saturate at all ones until clear or start.
`timescale 1ns/1ns
`include "vlan_stats_map.svh"

module vlan_stats #(
	parameter logic [31:0]        SEC_CYCLES = 32'(`RATE_WIN_MS * `CLK_KHZ),
	parameter logic [`LEN_W-1:0]  MAX_FRAME  = `MAX_FRAME_DEF
) (
	input  wire logic                 CLK_SYS,   // System clock, 125 MHz
	input  wire logic                 NRST,      // Async reset, low
	input  wire logic                 WB_CYC,    // Wishbone cycle
	input  wire logic                 WB_STB,    // Wishbone strobe
	input  wire logic                 WB_WE,     // Wishbone write
	input  wire logic [7:0]           WB_ADR,    // Byte address
	input  wire logic [3:0]           WB_SEL,    // Byte enables
	input  wire logic [31:0]          WB_DAT_I,  // Write data
	output logic      [31:0]          WB_DAT_O,  // Read data
	output logic                      WB_ACK,    // Acknowledge
	input  wire logic                 RX_EOF,    // RX frame end pulse
	input  wire logic [`LEN_W-1:0]    RX_LEN,    // RX frame length
	input  wire logic [`VID_W-1:0]    RX_VID,    // RX frame VLAN id
	input  wire logic [`PORT_W-1:0]   RX_PORT,   // RX uplink port
	input  wire logic                 RX_MCAST,  // RX multicast
	input  wire logic                 RX_BCAST,  // RX broadcast
	input  wire logic                 RX_ERR,    // RX errored
	input  wire logic                 TX_EOF,    // TX frame end pulse
	input  wire logic [`LEN_W-1:0]    TX_LEN,    // TX frame length
	input  wire logic [`VID_W-1:0]    TX_VID,    // TX frame VLAN id
	input  wire logic [`PORT_W-1:0]   TX_PORT,   // TX uplink port
	input  wire logic                 TX_MCAST,  // TX multicast
	input  wire logic                 TX_BCAST,  // TX broadcast
	input  wire logic                 TX_ERR,    // TX errored
	output logic                      RUNNING    // Collection active
);
	import vlan_stats_pkg::*;

	typedef struct packed {
		logic                running;
		logic [`VID_W-1:0]   sel_vid;
		logic [`PORT_W-1:0]  sel_port;
		logic [`VID_W-1:0]   act_vid;
		logic [`PORT_W-1:0]  act_port;
		logic                ack;
		logic [31:0]         rdata;
		logic                clear;
		logic [31:0]         presc;
		logic                tick;
		logic [31:0]         up_sec;
		snap_t               snap;
	} top_st_t;

	top_st_t st_r;
	top_st_t st_nxt;

	logic [1:0]               eof_w;
	logic [1:0][`LEN_W-1:0]   len_w;
	logic [1:0][`VID_W-1:0]   vid_w;
	logic [1:0][`PORT_W-1:0]  port_w;
	logic [1:0]               mc_w;
	logic [1:0]               bc_w;
	logic [1:0]               err_w;
	logic [1:0]               match_w;
	snap_t                    cnt_w;

	assign eof_w  = {TX_EOF, RX_EOF};
	assign len_w  = {TX_LEN, RX_LEN};
	assign vid_w  = {TX_VID, RX_VID};
	assign port_w = {TX_PORT, RX_PORT};
	assign mc_w   = {TX_MCAST, RX_MCAST};
	assign bc_w   = {TX_BCAST, RX_BCAST};
	assign err_w  = {TX_ERR, RX_ERR};

	genvar d;
	generate
		for (d = 0; d < 2; d++) begin : g_dir
			// Only frames on the armed VLAN and port reach the counters
			assign match_w[d] = st_r.running && vid_w[d] == st_r.act_vid
				&& port_w[d] == st_r.act_port; // R1

			stats_dir #(
				.MAX_FRAME (MAX_FRAME)
			) u_dir (
				.clk   (CLK_SYS),
				.nrst  (NRST),
				.eof   (eof_w[d]),
				.match (match_w[d]),
				.len   (len_w[d]),
				.mcast (mc_w[d]),
				.bcast (bc_w[d]),
				.err   (err_w[d]),
				.clear (st_r.clear),
				.tick  (st_r.tick),
				.cnt_o (cnt_w[d])
			);

			bin_64_a: assert property (@(posedge CLK_SYS) disable iff (!NRST) // R10
				eof_w[d] && match_w[d] && len_w[d] == `LEN_64 && !st_r.clear
				|=> cnt_w[d][`IX_B64] == $past(cnt_w[d][`IX_B64]) + 32'h0000_0001
					|| $past(cnt_w[d][`IX_B64]) == '1)
				else $error("64-octet bin missed a frame");

			bin_65_a: assert property (@(posedge CLK_SYS) disable iff (!NRST) // R11
				eof_w[d] && match_w[d] && len_w[d] > `LEN_64 && len_w[d] <= `LEN_127
				&& err_w[d] && !st_r.clear
				&& cnt_w[d][5] != '1
				|=> cnt_w[d][5] == $past(cnt_w[d][5]) + 32'h0000_0001)
				else $error("65-127 bin missed an errored frame");

			bin_128_a: assert property (@(posedge CLK_SYS) disable iff (!NRST) // R12
				eof_w[d] && match_w[d] && len_w[d] > `LEN_127 && len_w[d] <= `LEN_255
				&& !st_r.clear && cnt_w[d][6] != '1
				|=> cnt_w[d][6] == $past(cnt_w[d][6]) + 32'h0000_0001)
				else $error("128-255 bin missed a frame");

			bin_256_a: assert property (@(posedge CLK_SYS) disable iff (!NRST) // R13
				eof_w[d] && match_w[d] && len_w[d] > `LEN_255 && len_w[d] <= `LEN_511
				&& !st_r.clear && cnt_w[d][7] != '1
				|=> cnt_w[d][7] == $past(cnt_w[d][7]) + 32'h0000_0001)
				else $error("256-511 bin missed a frame");

			bin_512_a: assert property (@(posedge CLK_SYS) disable iff (!NRST) // R14
				eof_w[d] && match_w[d] && len_w[d] > `LEN_511 && len_w[d] <= `LEN_1023
				&& !st_r.clear && cnt_w[d][8] != '1
				|=> cnt_w[d][8] == $past(cnt_w[d][8]) + 32'h0000_0001)
				else $error("512-1023 bin missed a frame");

			bin_1024_a: assert property (@(posedge CLK_SYS) disable iff (!NRST) // R15
				eof_w[d] && match_w[d] && len_w[d] > `LEN_1023 && len_w[d] <= `LEN_1518
				&& !st_r.clear && cnt_w[d][9] != '1
				|=> cnt_w[d][9] == $past(cnt_w[d][9]) + 32'h0000_0001)
				else $error("1024-1518 bin missed a frame");

			no_bin_a: assert property (@(posedge CLK_SYS) disable iff (!NRST) // R16
				eof_w[d] && match_w[d] && (len_w[d] < `LEN_64 || len_w[d] > MAX_FRAME)
				&& !st_r.clear
				|=> cnt_w[d][`IX_GIANT:`IX_B64] == $past(cnt_w[d][`IX_GIANT:`IX_B64]))
				else $error("out-of-range frame landed in a bin");

			giant_bin_a: assert property (@(posedge CLK_SYS) disable iff (!NRST) // R16
				eof_w[d] && match_w[d] && len_w[d] == 14'h05EF && !st_r.clear
				&& cnt_w[d][`IX_GIANT] != '1
				|=> cnt_w[d][`IX_GIANT] == $past(cnt_w[d][`IX_GIANT]) + 32'h0000_0001
					&& cnt_w[d][9] == $past(cnt_w[d][9]))
				else $error("1519-octet frame not in giant bin");

			mcast_good_a: assert property (@(posedge CLK_SYS) disable iff (!NRST) // R8
				eof_w[d] && err_w[d] && !st_r.clear
				|=> cnt_w[d][`IX_MCAST] == $past(cnt_w[d][`IX_MCAST]))
				else $error("errored frame counted as multicast");

			bcast_good_a: assert property (@(posedge CLK_SYS) disable iff (!NRST) // R9
				eof_w[d] && match_w[d] && bc_w[d] && !err_w[d] && !st_r.clear
				&& cnt_w[d][`IX_BCAST] != '1
				|=> cnt_w[d][`IX_BCAST] == $past(cnt_w[d][`IX_BCAST]) + 32'h0000_0001)
				else $error("good broadcast not counted");

			byte_sum_a: assert property (@(posedge CLK_SYS) disable iff (!NRST) // R6
				eof_w[d] && match_w[d] && !st_r.clear
				|=> cnt_w[d][`IX_BYTES] == sat_add($past(cnt_w[d][`IX_BYTES]),
					32'($past(len_w[d]))))
				else $error("byte count wrong");

			no_match_a: assert property (@(posedge CLK_SYS) disable iff (!NRST) // R1
				!st_r.running && !st_r.clear
				|=> cnt_w[d][`IX_BYTES] == $past(cnt_w[d][`IX_BYTES]))
				else $error("bytes counted while stopped");

			sat_hold_a: assert property (@(posedge CLK_SYS) disable iff (!NRST) // R18
				cnt_w[d][`IX_BYTES] == '1 && !st_r.clear |=> cnt_w[d][`IX_BYTES] == '1)
				else $error("byte counter wrapped");

			clear_zero_a: assert property (@(posedge CLK_SYS) disable iff (!NRST) // R5
				st_r.clear |=> cnt_w[d] == '0)
				else $error("clear left a counter nonzero");
		end
	endgenerate

	logic        wb_req;
	logic        ctl_wr;
	logic [1:0]  page;
	logic [3:0]  slot;

	assign wb_req = WB_CYC && WB_STB && !st_r.ack;
	assign ctl_wr = wb_req && WB_WE && WB_ADR == `OFS_CTRL && WB_SEL[0];
	assign page   = WB_ADR[7:6];
	assign slot   = WB_ADR[5:2];

	always_comb begin
		st_nxt       = st_r;
		st_nxt.ack   = 1'b0;
		st_nxt.clear = 1'b0;
		st_nxt.tick  = 1'b0;

		// Uptime and rate window share one prescaler
		if (st_r.presc >= SEC_CYCLES - 32'h0000_0001) begin
			st_nxt.presc  = '0;
			st_nxt.tick   = 1'b1;
			st_nxt.up_sec = sat_add(st_r.up_sec, 32'h0000_0001); // R17
		end else begin
			st_nxt.presc = st_r.presc + 32'h0000_0001;
		end

		if (wb_req) begin
			st_nxt.ack   = 1'b1;
			st_nxt.rdata = '0;
			if (WB_WE) begin
				if (WB_ADR == `OFS_SEL) begin
					if (WB_SEL[0])
						st_nxt.sel_vid[7:0] = WB_DAT_I[7:0];
					if (WB_SEL[1])
						st_nxt.sel_vid[`VID_W-1:8] = WB_DAT_I[`VID_W-1:8];
					if (WB_SEL[2])
						st_nxt.sel_port = WB_DAT_I[`SEL_PORT_LSB +: `PORT_W];
				end
			end else begin
				unique case (WB_ADR)
					`OFS_SEL: begin
						st_nxt.rdata[`SEL_VID_LSB +: `VID_W]   = st_r.sel_vid;
						st_nxt.rdata[`SEL_PORT_LSB +: `PORT_W] = st_r.sel_port;
					end
					`OFS_STATUS: begin
						st_nxt.rdata[`STAT_RUN_BIT]             = st_r.running;
						st_nxt.rdata[`STAT_VID_LSB +: `VID_W]   = st_r.act_vid;
						st_nxt.rdata[`STAT_PORT_LSB +: `PORT_W] = st_r.act_port;
					end
					`OFS_UPTIME:
						st_nxt.rdata = st_r.up_sec; // R17
					default: begin
						// Counter pages; unmapped words read zero
						if ((page == `DIR_RX_PAGE || page == `DIR_TX_PAGE)
							&& slot < 4'(`NCNT))
							st_nxt.rdata = st_r.snap[page[1]][slot];
					end
				endcase
			end
		end

		if (ctl_wr) begin
			if (WB_DAT_I[`CMD_START]) begin
				// A new start arms the staged selection and restarts counts
				st_nxt.running  = 1'b1; // R1
				st_nxt.act_vid  = st_r.sel_vid;
				st_nxt.act_port = st_r.sel_port;
				st_nxt.clear    = 1'b1; // R18
				st_nxt.snap     = '0;
			end else if (st_r.running) begin // R2
				if (WB_DAT_I[`CMD_STOP]) begin
					st_nxt.running  = 1'b0; // R3
					st_nxt.act_vid  = `VID_DEF;
					st_nxt.act_port = `PORT_DEF;
					st_nxt.sel_vid  = `VID_DEF;
					st_nxt.sel_port = `PORT_DEF;
				end else if (WB_DAT_I[`CMD_CLEAR]) begin
					st_nxt.clear = 1'b1; // R5
					st_nxt.snap  = '0;
				end else if (WB_DAT_I[`CMD_REFRESH]) begin
					st_nxt.snap = cnt_w; // R4
				end
			end
		end
	end

	always_ff @(posedge CLK_SYS or negedge NRST) begin
		if (!NRST) begin
			st_r          <= '0;
			st_r.sel_vid  <= `VID_DEF;
			st_r.act_vid  <= `VID_DEF;
			st_r.sel_port <= `PORT_DEF;
			st_r.act_port <= `PORT_DEF;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign WB_DAT_O = st_r.rdata;
	assign WB_ACK   = st_r.ack;
	assign RUNNING  = st_r.running;

	idle_cmd_a: assert property (@(posedge CLK_SYS) disable iff (!NRST) // R2
		!st_r.running && ctl_wr && !WB_DAT_I[`CMD_START]
		|=> !st_r.running && !st_r.clear && $stable(st_r.snap))
		else $error("command acted while idle");

	stop_dflt_a: assert property (@(posedge CLK_SYS) disable iff (!NRST) // R3
		st_r.running && ctl_wr && !WB_DAT_I[`CMD_START] && WB_DAT_I[`CMD_STOP]
		|=> !st_r.running && st_r.act_vid == `VID_DEF && st_r.act_port == `PORT_DEF
			&& st_r.sel_vid == `VID_DEF)
		else $error("stop did not restore defaults");

	refresh_copy_a: assert property (@(posedge CLK_SYS) disable iff (!NRST) // R4
		st_r.running && ctl_wr && WB_DAT_I[3:0] == 4'h4
		|=> st_r.snap == $past(cnt_w))
		else $error("refresh did not take live counters");

	start_arm_a: assert property (@(posedge CLK_SYS) disable iff (!NRST) // R1
		ctl_wr && WB_DAT_I[`CMD_START]
		|=> st_r.running && st_r.clear && st_r.act_vid == $past(st_r.sel_vid))
		else $error("start did not arm selection");

	uptime_step_a: assert property (@(posedge CLK_SYS) disable iff (!NRST) // R17
		st_r.tick |-> st_r.up_sec == $past(st_r.up_sec) + 32'h0000_0001
			|| st_r.up_sec == '1)
		else $error("uptime did not advance on tick");

	ack_one_a: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		WB_CYC && WB_STB && !WB_ACK |=> WB_ACK ##1 !WB_ACK)
		else $error("ack not a single cycle after request");

	ack_idle_a: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		!(WB_CYC && WB_STB) |=> !WB_ACK)
		else $error("ack without a request");

	sel_write_a: assert property (@(posedge CLK_SYS) disable iff (!NRST) // R1
		wb_req && WB_WE && WB_ADR == `OFS_SEL && WB_SEL == 4'hF
		|=> st_r.sel_vid == $past(WB_DAT_I[`SEL_VID_LSB +: `VID_W])
			&& st_r.sel_port == $past(WB_DAT_I[`SEL_PORT_LSB +: `PORT_W]))
		else $error("selection write not stored");

	run_hold_a: assert property (@(posedge CLK_SYS) disable iff (!NRST) // R2
		!ctl_wr |=> $stable(st_r.running))
		else $error("running changed without a command");
endmodule

// ---- dv/frame_src.sv ----
/*
 Far-side model of one uplink frame path: one end-of-frame pulse per send.
 Assumes the caller sits on the clock edge; sends are two cycles apart.
*/
`timescale 1ns/1ns
`include "vlan_stats_map.svh"

module frame_src (
	input  wire logic          clk,   // System clock
	output logic               eof,   // Frame end pulse
	output logic [`LEN_W-1:0]  len,   // Frame length
	output logic [`VID_W-1:0]  vid,   // VLAN id
	output logic [`PORT_W-1:0] port,  // Uplink port
	output logic               mcast, // Multicast
	output logic               bcast, // Broadcast
	output logic               err    // Errored
);
	initial begin
		{eof, len, vid, port, mcast, bcast, err} = '0;
	end

	task automatic send(input logic [`LEN_W-1:0] l, input logic [`VID_W-1:0] v,
		input logic [`PORT_W-1:0] p, input logic [2:0] mbe);
		@(posedge clk);
		{eof, len, vid, port, mcast, bcast, err} <= {1'b1, l, v, p, mbe};
		@(posedge clk);
		// Qualifiers are void outside the pulse: never leave a stale value
		{eof, len, vid, port, mcast, bcast, err} <= {1'b0, ~l, ~v, ~p, ~mbe};
	endtask
endmodule

// ---- dv/tb_vlan_stats.sv ----
/*
 Self-checking bench of the VLAN statistics block: Wishbone master tasks,
 a table of frames, then start, stop, clear, refresh, rate and uptime cases.
 Assumes a one-second window shortened to 100 cycles.
*/
`timescale 1ns/1ns
`include "vlan_stats_map.svh"

module tb_vlan_stats;
	import vlan_stats_pkg::*;
	typedef struct packed {
		logic        tx;
		logic [13:0] len;
		logic [11:0] vid;
		logic [3:0]  port;
		logic [2:0]  mbe;
		logic [3:0]  bin;
	} row_t;
	localparam row_t ROWS [19] = '{
		{1'h0, 14'h0040, 12'h005, 4'h3, 3'h0, 4'h4}, {1'h1, 14'h0040, 12'h005, 4'h3, 3'h1, 4'h4},
		{1'h0, 14'h003F, 12'h005, 4'h3, 3'h0, 4'hF}, {1'h0, 14'h0041, 12'h005, 4'h3, 3'h4, 4'h5},
		{1'h1, 14'h007F, 12'h005, 4'h3, 3'h5, 4'h5}, {1'h0, 14'h0080, 12'h005, 4'h3, 3'h2, 4'h6},
		{1'h1, 14'h00FF, 12'h005, 4'h3, 3'h3, 4'h6}, {1'h0, 14'h0100, 12'h005, 4'h3, 3'h0, 4'h7},
		{1'h1, 14'h01FF, 12'h005, 4'h3, 3'h0, 4'h7}, {1'h0, 14'h0200, 12'h005, 4'h3, 3'h0, 4'h8},
		{1'h1, 14'h03FF, 12'h005, 4'h3, 3'h0, 4'h8}, {1'h0, 14'h0400, 12'h005, 4'h3, 3'h0, 4'h9},
		{1'h1, 14'h05EE, 12'h005, 4'h3, 3'h0, 4'h9}, {1'h0, 14'h05EF, 12'h005, 4'h3, 3'h0, 4'hA},
		{1'h1, 14'h2400, 12'h005, 4'h3, 3'h1, 4'hA}, {1'h0, 14'h2401, 12'h005, 4'h3, 3'h0, 4'hF},
		{1'h0, 14'h0064, 12'h006, 4'h3, 3'h4, 4'hF}, {1'h1, 14'h0064, 12'h005, 4'h2, 3'h2, 4'hF},
		{1'h1, 14'h0064, 12'h005, 4'h3, 3'h4, 4'h5}};
	int          num_errors = 0;
	int          num_checks = 0;
	logic        clk = 1'b0, nrst = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, running;
	logic [7:0]  adr = '0;
	logic [3:0]  sel = '0;
	logic [31:0] dat_i = '0, dat_o, q;
	logic        rx_eof, rx_mc, rx_bc, rx_er, tx_eof, tx_mc, tx_bc, tx_er;
	logic [13:0] rx_len, tx_len;
	logic [11:0] rx_vid, tx_vid;
	logic [3:0]  rx_port, tx_port;
	snap_t       ex = '0;

	vlan_stats #(.SEC_CYCLES(32'h0000_0064)) dut (.CLK_SYS(clk), .NRST(nrst), .WB_CYC(cyc),
		.WB_STB(stb), .WB_WE(we), .WB_ADR(adr), .WB_SEL(sel), .WB_DAT_I(dat_i),
		.WB_DAT_O(dat_o), .WB_ACK(ack), .RX_EOF(rx_eof), .RX_LEN(rx_len), .RX_VID(rx_vid),
		.RX_PORT(rx_port), .RX_MCAST(rx_mc), .RX_BCAST(rx_bc), .RX_ERR(rx_er),
		.TX_EOF(tx_eof), .TX_LEN(tx_len), .TX_VID(tx_vid), .TX_PORT(tx_port),
		.TX_MCAST(tx_mc), .TX_BCAST(tx_bc), .TX_ERR(tx_er), .RUNNING(running));
	frame_src rx_src (.clk(clk), .eof(rx_eof), .len(rx_len), .vid(rx_vid), .port(rx_port),
		.mcast(rx_mc), .bcast(rx_bc), .err(rx_er));
	frame_src tx_src (.clk(clk), .eof(tx_eof), .len(tx_len), .vid(tx_vid), .port(tx_port),
		.mcast(tx_mc), .bcast(tx_bc), .err(tx_er));

	initial begin
		forever #4 clk = ~clk;
	end

	task automatic report_and_stop();
		if (num_errors == 0 && num_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= 4'hF;
		dat_i <= d;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 50);
		q = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		if (ack !== 1'b1) begin
			num_errors++;
			report_and_stop();
		end
	endtask

	task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
		wb(1'b0, a, '0);
		chk(nm, e, q);
	endtask

	initial begin
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		chk("ack", 1'b0, ack);
		rd_chk("status", `OFS_STATUS, 32'h0000_0010);
		rx_src.send(14'h0040, `VID_DEF, `PORT_DEF, 3'h4);
		for (int c = 1; c < 4; c++) wb(1'b1, `OFS_CTRL, 32'(1 << c));
		chk("running", 1'b0, running);
		wb(1'b1, `OFS_SEL, 32'h0003_0005);
		wb(1'b1, `OFS_CTRL, 32'h0000_0001);
		chk("running", 1'b1, running);
		rd_chk("status", `OFS_STATUS, 32'h0003_0051);
		foreach (ROWS[k]) begin
			if (ROWS[k].tx) tx_src.send(ROWS[k].len, ROWS[k].vid, ROWS[k].port, ROWS[k].mbe);
			else rx_src.send(ROWS[k].len, ROWS[k].vid, ROWS[k].port, ROWS[k].mbe);
			if (ROWS[k].vid == 12'h005 && ROWS[k].port == 4'h3) begin
				ex[ROWS[k].tx][`IX_BYTES] += 32'(ROWS[k].len);
				if (ROWS[k].mbe == 3'h4) ex[ROWS[k].tx][`IX_MCAST] += 1;
				if (ROWS[k].mbe == 3'h2) ex[ROWS[k].tx][`IX_BCAST] += 1;
				if (ROWS[k].bin != 4'hF) ex[ROWS[k].tx][ROWS[k].bin] += 1;
			end
		end
		wb(1'b1, `OFS_CTRL, 32'h0000_0004);
		for (int d = 0; d < 2; d++) for (int i = 1; i < `NCNT; i++) begin
			rd_chk($sformatf("dir%0d slot%0d", d, i), 8'(8'h40 << d) + 8'(i * 4),
				ex[d][i]);
		end
		rd_chk("unmapped", 8'h6C, 32'h0000_0000);
		wb(1'b1, `OFS_CTRL, 32'h0000_0008);
		wb(1'b1, `OFS_CTRL, 32'h0000_0004);
		rd_chk("tx giant", 8'hA8, 32'h0000_0000);
		// Ten 1000-byte frames in every 100-cycle window
		repeat (30) begin
			rx_src.send(14'h03E8, 12'h005, 4'h3, 3'h0);
			repeat (8) @(posedge clk);
		end
		wb(1'b1, `OFS_CTRL, 32'h0000_0004);
		rd_chk("rate", 8'h40, 32'h0000_000A);
		rd_chk("bytes", 8'h44, 32'h0000_7530);
		rd_chk("tx bytes", 8'h84, 32'h0000_0000);
		rx_src.send(14'h0040, 12'h005, 4'h3, 3'h0);
		rd_chk("stale", 8'h44, 32'h0000_7530);
		wb(1'b1, `OFS_CTRL, 32'h0000_0004);
		rd_chk("fresh", 8'h44, 32'h0000_7570);
		wb(1'b1, `OFS_CTRL, 32'h0000_0005);
		rd_chk("restart", 8'h44, 32'h0000_0000);
		wb(1'b0, `OFS_UPTIME, '0);
		dat_i <= q;
		repeat (497) @(posedge clk);
		rd_chk("uptime", `OFS_UPTIME, dat_i + 32'h0000_0005);
		wb(1'b1, `OFS_CTRL, 32'h0000_0002);
		chk("running", 1'b0, running);
		rd_chk("sel", `OFS_SEL, 32'h0000_0001);
		wb(1'b1, `OFS_CTRL, 32'h0000_0001);
		@(posedge clk);
		nrst <= 1'b0;
		@(posedge clk);
		chk("running", 1'b0, running);
		nrst <= 1'b1;
		rd_chk("status", `OFS_STATUS, 32'h0000_0010);
		report_and_stop();
	end
endmodule
